// ---- hdl/cku_pkg.sv ----
// Constants, carriers and CRC arithmetic shared by the checksum unit
package cku_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets (byte addresses within the unit)
  localparam logic [4:0] OFS_WIDE_DATA   = 5'h00;
  localparam logic [4:0] OFS_SCRATCH     = 5'h04;
  localparam logic [4:0] OFS_WIDE_CTRL   = 5'h08;
  localparam logic [4:0] OFS_NARROW_CTRL = 5'h0C;
  localparam logic [4:0] OFS_NARROW_IN   = 5'h10;
  localparam logic [4:0] OFS_NARROW_RES  = 5'h14;
  localparam logic [4:0] OFS_XOR_CHECK   = 5'h18;
  localparam int         OFS_BITS        = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int WIDE_REINIT_BIT   = 0;
  localparam int INPUT_ORDER_BIT   = 1;
  localparam int RESULT_WIPE_BIT   = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and polynomials
  localparam logic [31:0] WIDE_RESET_VALUE   = 32'hFFFF_FFFF;
  localparam logic [7:0]  SCRATCH_RESET      = 8'h00;
  localparam logic [15:0] NARROW_RESET_VALUE = 16'h0000;
  localparam logic [7:0]  XOR_RESET_VALUE    = 8'h00;
  localparam logic [31:0] WIDE_POLY          = 32'h04C1_1DB7;
  localparam logic [15:0] NARROW_POLY        = 16'h8005;

  ////////////////////////////////////////////////////////////////////////////
  // Bus encodings
  localparam int         HTRANS_ACTIVE_BIT = 1;
  localparam logic [2:0] HSIZE_BYTE        = 3'h0;
  localparam logic [2:0] HSIZE_HALF        = 3'h1;
  localparam logic [3:0] ALL_LANES         = 4'hF;

  // Address phase captured for the data phase
  typedef struct packed {
    logic [4:0] addr;
    logic       write;
    logic [3:0] lanes;
  } cku_xfer_t;

  // Commands toward the byte-wide engine
  typedef struct packed {
    logic        byte_wr;
    logic [7:0]  byte_data;
    logic        lsb_first;
    logic        wipe;
    logic [1:0]  res_lanes;
    logic [15:0] res_data;
    logic        xor_wr;
    logic [7:0]  xor_data;
  } cku_narrow_cmd_t;

  ////////////////////////////////////////////////////////////////////////////
  // Arithmetic
  function automatic logic [31:0] cku_wide_step(input logic [31:0] crc,
                                                input logic [31:0] data);
    logic [31:0] c;
    logic        fb;
    c = crc;
    for (int i = 31; i >= 0; i--)
    begin
      fb = c[31] ^ data[i];
      c  = {c[30:0], 1'b0} ^ (fb ? WIDE_POLY : 32'h0000_0000);
    end
    return c;
  endfunction : cku_wide_step

  function automatic logic [15:0] cku_narrow_step(input logic [15:0] crc,
                                                  input logic [7:0]  data);
    logic [15:0] c;
    logic        fb;
    c = crc;
    for (int i = 7; i >= 0; i--)
    begin
      fb = c[15] ^ data[i];
      c  = {c[14:0], 1'b0} ^ (fb ? NARROW_POLY : 16'h0000);
    end
    return c;
  endfunction : cku_narrow_step

  function automatic logic [7:0] cku_reverse8(input logic [7:0] d);
    logic [7:0] r;
    for (int i = 0; i < 8; i++)
    begin
      r[i] = d[7 - i];
    end
    return r;
  endfunction : cku_reverse8

endpackage : cku_pkg

// ---- hdl/cku_narrow.sv ----
// Byte-wide CRC16 engine with parallel XOR longitudinal check
`timescale 1ns/100ps
module cku_narrow (
  input  wire logic                     clock,
  input  wire logic                     rstn,
  input  wire cku_pkg::cku_narrow_cmd_t cmd,
  output logic [15:0]                   result,
  output logic [7:0]                    xor_check
);
  import cku_pkg::*;

  logic [15:0] next_result;
  logic [7:0]  next_xor_check;
  logic [7:0]  ordered;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    ordered        = cmd.lsb_first ? cku_reverse8(cmd.byte_data) : cmd.byte_data;
    next_result    = result;
    next_xor_check = xor_check;
    if (cmd.wipe)
    begin
      next_result = NARROW_RESET_VALUE;
    end
    else if (cmd.byte_wr)
    begin
      next_result = cku_narrow_step(result, ordered);
    end
    else
    begin
      if (cmd.res_lanes[0])
      begin
        next_result[7:0] = cmd.res_data[7:0];
      end
      if (cmd.res_lanes[1])
      begin
        next_result[15:8] = cmd.res_data[15:8];
      end
    end
    if (cmd.byte_wr)
    begin
      next_xor_check = xor_check ^ cmd.byte_data;
    end
    else if (cmd.xor_wr)
    begin
      next_xor_check = cmd.xor_data;
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      result    <= NARROW_RESET_VALUE;
      xor_check <= XOR_RESET_VALUE;
    end
    else
    begin
      result    <= next_result;
      xor_check <= next_xor_check;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  sequence s_byte_in;
    cmd.byte_wr && !cmd.wipe;
  endsequence

  AST_NARROW_STEP: assert property (
    s_byte_in |=> result == cku_narrow_step($past(result),
      $past(cmd.lsb_first) ? cku_reverse8($past(cmd.byte_data)) : $past(cmd.byte_data)))
    else $error("narrow result did not step on byte write");
  AST_NARROW_WIPE: assert property (
    cmd.wipe |=> result == 16'h0000)
    else $error("narrow result not wiped");
  AST_XOR_ACCUM: assert property (
    s_byte_in |=> xor_check == ($past(xor_check) ^ $past(cmd.byte_data)))
    else $error("xor check not accumulated");
  AST_NARROW_HOLD: assert property (
    !cmd.byte_wr && !cmd.wipe && cmd.res_lanes == 2'b00 |=> $stable(result))
    else $error("narrow result changed without cause");
  AST_NARROW_LOW_LANE: assert property (
    !cmd.wipe && !cmd.byte_wr && cmd.res_lanes == 2'b01
      |=> result == {$past(result[15:8]), $past(cmd.res_data[7:0])})
    else $error("byte write to result touched the wrong half");

endmodule : cku_narrow

// ---- hdl/cku_unit.sv ----
// Memory-mapped CRC32, scratch byte, CRC16 and XOR check unit on AHB-lite
`timescale 1ns/100ps
module cku_unit #(
  parameter int ADDR_W = 12
) (
  input  wire logic              clock,
  input  wire logic              rstn,
  input  wire logic              hsel,
  input  wire logic [ADDR_W-1:0] haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic              hready,
  input  wire logic [31:0]       hwdata,
  output logic [31:0]            hrdata,
  output logic                   hreadyout,
  output logic                   hresp
);
  import cku_pkg::*;

  if (ADDR_W < OFS_BITS || ADDR_W > 32)
  begin : g_bad_width
    $error("cku_unit: ADDR_W must lie between 5 and 32");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Byte lanes from transfer size and low address bits
  function automatic logic [3:0] lane_mask(input logic [2:0] size,
                                           input logic [1:0] low);
    logic [3:0] m;
    case (size)
      HSIZE_BYTE: m = 4'h1 << low;
      HSIZE_HALF: m = low[1] ? 4'hC : 4'h3;
      default:    m = ALL_LANES;
    endcase
    return m;
  endfunction : lane_mask

  ////////////////////////////////////////////////////////////////////////////
  // Bus phase tracking
  cku_xfer_t xfer;
  cku_xfer_t next_xfer;
  logic      xfer_vld;
  logic      next_xfer_vld;

  always_comb
  begin
    next_xfer     = xfer;
    next_xfer_vld = xfer_vld;
    if (hready)
    begin
      next_xfer_vld = hsel && htrans[HTRANS_ACTIVE_BIT];
      // Registers are decoded by word; the low address bits only pick lanes
      next_xfer     = '{addr:  {haddr[OFS_BITS-1:2], 2'b00},
                        write: hwrite,
                        lanes: lane_mask(hsize, haddr[1:0])};
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      xfer     <= '0;
      xfer_vld <= 1'b0;
    end
    else
    begin
      xfer     <= next_xfer;
      xfer_vld <= next_xfer_vld;
    end
  end

  // Zero wait states: every engine finishes within the data phase
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  logic wr;
  logic rd;
  assign wr = xfer_vld && xfer.write;
  assign rd = xfer_vld && !xfer.write;

  ////////////////////////////////////////////////////////////////////////////
  // Word engine, scratch byte and CRC16 control state
  logic [31:0] wide_check_data;
  logic [31:0] next_wide_check_data;
  logic [7:0]  scratch_byte_value;
  logic [7:0]  next_scratch_byte_value;
  logic        input_bit_order;
  logic        next_input_bit_order;
  logic [7:0]  narrow_input_byte;
  logic [7:0]  next_narrow_input_byte;
  logic        wide_word_wr;
  logic        wide_reinit;

  // word writes only; narrow writes to the word engine are dropped
  assign wide_word_wr = wr && xfer.addr == OFS_WIDE_DATA && xfer.lanes == ALL_LANES;
  assign wide_reinit  = wr && xfer.addr == OFS_WIDE_CTRL && xfer.lanes[0]
                        && hwdata[WIDE_REINIT_BIT];

  always_comb
  begin
    next_wide_check_data    = wide_check_data;
    next_scratch_byte_value = scratch_byte_value;
    next_input_bit_order    = input_bit_order;
    next_narrow_input_byte  = narrow_input_byte;
    if (wide_word_wr)
    begin
      next_wide_check_data = cku_wide_step(wide_check_data, hwdata);
    end
    else if (wide_reinit)
    begin
      next_wide_check_data = WIDE_RESET_VALUE;
    end
    if (wr && xfer.addr == OFS_SCRATCH && xfer.lanes[0])
    begin
      next_scratch_byte_value = hwdata[7:0];
    end
    if (wr && xfer.addr == OFS_NARROW_CTRL && xfer.lanes[0])
    begin
      next_input_bit_order = hwdata[INPUT_ORDER_BIT];
    end
    if (wr && xfer.addr == OFS_NARROW_IN && xfer.lanes[0])
    begin
      next_narrow_input_byte = hwdata[7:0];
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      wide_check_data    <= WIDE_RESET_VALUE;
      scratch_byte_value <= SCRATCH_RESET;
      input_bit_order    <= 1'b0;
      narrow_input_byte  <= 8'h00;
    end
    else
    begin
      wide_check_data    <= next_wide_check_data;
      scratch_byte_value <= next_scratch_byte_value;
      input_bit_order    <= next_input_bit_order;
      narrow_input_byte  <= next_narrow_input_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Byte-wide engine
  cku_narrow_cmd_t narrow_cmd;
  logic [15:0]     narrow_result_value;
  logic [7:0]      xor_check_value;

  always_comb
  begin
    narrow_cmd.byte_wr   = wr && xfer.addr == OFS_NARROW_IN && xfer.lanes[0];
    narrow_cmd.byte_data = hwdata[7:0];
    // The order in force is the stored one; a same-cycle change applies next byte
    narrow_cmd.lsb_first = input_bit_order;
    narrow_cmd.wipe      = wr && xfer.addr == OFS_NARROW_CTRL && xfer.lanes[0]
                           && hwdata[RESULT_WIPE_BIT];
    narrow_cmd.res_lanes = (wr && xfer.addr == OFS_NARROW_RES) ? xfer.lanes[1:0] : 2'b00;
    narrow_cmd.res_data  = hwdata[15:0];
    narrow_cmd.xor_wr    = wr && xfer.addr == OFS_XOR_CHECK && xfer.lanes[0];
    narrow_cmd.xor_data  = hwdata[7:0];
  end

  cku_narrow u_narrow (
    .clock     (clock),
    .rstn      (rstn),
    .cmd       (narrow_cmd),
    .result    (narrow_result_value),
    .xor_check (xor_check_value)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read data; registers are flops so a read right after a write sees the new value
  always_comb
  begin
    hrdata = 32'h0000_0000;
    if (rd)
    begin
      case (xfer.addr)
        OFS_WIDE_DATA:   hrdata = wide_check_data;
        OFS_SCRATCH:     hrdata = {24'h00_0000, scratch_byte_value};
        OFS_WIDE_CTRL:   hrdata = 32'h0000_0000;
        OFS_NARROW_CTRL: hrdata = {30'h0000_0000, input_bit_order, 1'b0};
        OFS_NARROW_IN:   hrdata = {24'h00_0000, narrow_input_byte};
        OFS_NARROW_RES:  hrdata = {16'h0000, narrow_result_value};
        OFS_XOR_CHECK:   hrdata = {24'h00_0000, xor_check_value};
        default:         hrdata = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  sequence s_word_write;
    wide_word_wr;
  endsequence

  sequence s_reinit;
    wide_reinit;
  endsequence

  AST_WIDE_STEP: assert property (
    s_word_write |=> wide_check_data == cku_wide_step($past(wide_check_data), $past(hwdata)))
    else $error("word engine did not step on write");
  AST_WIDE_BACK_TO_BACK: assert property (
    s_word_write ##1 s_word_write |=> wide_check_data == cku_wide_step(
      cku_wide_step($past(wide_check_data, 2), $past(hwdata, 2)), $past(hwdata)))
    else $error("back to back word writes not chained");
  AST_WIDE_REINIT: assert property (
    s_reinit |=> wide_check_data == 32'hFFFF_FFFF)
    else $error("reinit did not load all ones");
  AST_SCRATCH_KEEP: assert property (
    !(wr && xfer.addr == OFS_SCRATCH) |=> $stable(scratch_byte_value))
    else $error("scratch byte changed without a write to it");
  AST_WIDE_READ: assert property (
    rd && xfer.addr == OFS_WIDE_DATA |-> hrdata == wide_check_data)
    else $error("word read did not return the result");
  AST_NARROW_CTRL_READ: assert property (
    rd && xfer.addr == OFS_NARROW_CTRL |-> hrdata[31:2] == 30'h0 && !hrdata[0])
    else $error("wipe or reserved control bit read as one");
  AST_ORDER_KEEP: assert property (
    wr && xfer.addr == OFS_NARROW_CTRL && xfer.lanes[0]
      |=> input_bit_order == $past(hwdata[INPUT_ORDER_BIT]))
    else $error("order bit not stored");
  AST_RESERVED_ZERO: assert property (
    rd && xfer.addr == OFS_XOR_CHECK |-> hrdata[31:8] == 24'h0 && hrdata[7:0] == xor_check_value)
    else $error("check byte read wrong");

  ////////////////////////////////////////////////////////////////////////////
  // Stored values, ignored writes and reserved bits, checked at the bus
  sequence s_word_read;
    rd && xfer.addr == OFS_WIDE_DATA;
  endsequence

  AST_WRITE_THEN_READ: assert property (
    s_word_write ##1 s_word_read
      |-> hrdata == cku_wide_step($past(wide_check_data), $past(hwdata)))
    else $error("read right after a word write missed the new result");
  AST_WIDE_SUBWORD_DROP: assert property (
    wr && xfer.addr == OFS_WIDE_DATA && xfer.lanes != ALL_LANES |=> $stable(wide_check_data))
    else $error("sub-word write changed the word result");
  AST_WIDE_ZERO_WRITE: assert property (
    wr && xfer.addr == OFS_WIDE_CTRL && !hwdata[WIDE_REINIT_BIT] |=> $stable(wide_check_data))
    else $error("writing zero to the reinit bit changed the result");
  AST_WIDE_CTRL_READ: assert property (
    rd && xfer.addr == OFS_WIDE_CTRL |-> hrdata == 32'h0000_0000)
    else $error("reinit bit read as one");
  AST_SCRATCH_WRITE: assert property (
    wr && xfer.addr == OFS_SCRATCH && xfer.lanes[0]
      |=> scratch_byte_value == $past(hwdata[7:0]))
    else $error("scratch byte not stored");
  AST_INPUT_BYTE_STORE: assert property (
    wr && xfer.addr == OFS_NARROW_IN && xfer.lanes[0]
      |=> narrow_input_byte == $past(hwdata[7:0]))
    else $error("input byte not stored");
  AST_WIPE_FROM_BUS: assert property (
    wr && xfer.addr == OFS_NARROW_CTRL && xfer.lanes[0] && hwdata[RESULT_WIPE_BIT]
      |=> narrow_result_value == NARROW_RESET_VALUE)
    else $error("wipe bit write did not zero the result");
  AST_RESULT_HIGH_LANE: assert property (
    wr && xfer.addr == OFS_NARROW_RES && xfer.lanes[1:0] == 2'b10
      |=> narrow_result_value == {$past(hwdata[15:8]), $past(narrow_result_value[7:0])})
    else $error("byte write to the upper result half touched the wrong half");
  AST_BYTE_REG_RESERVED: assert property (
    rd && (xfer.addr == OFS_SCRATCH || xfer.addr == OFS_NARROW_IN) |-> hrdata[31:8] == 24'h0)
    else $error("reserved bits of a byte register read as one");
  AST_RESULT_RESERVED: assert property (
    rd && xfer.addr == OFS_NARROW_RES |-> hrdata[31:16] == 16'h0)
    else $error("reserved result bits read as one");
  AST_UNMAPPED_ZERO: assert property (
    rd && xfer.addr > OFS_XOR_CHECK |-> hrdata == 32'h0000_0000)
    else $error("unmapped offset read nonzero");

endmodule : cku_unit

// ---- dv/tb_cku_unit.sv ----
// Self-checking bench for the checksum unit, driven over its register bus
`timescale 1ns/100ps
module tb_cku_unit;
  import cku_pkg::*;
  logic        clock;
  logic        rstn;
  logic        hsel;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic        hready;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  int          errors = 0;
  int          total_checks = 0;
  int          cycles = 0;
  logic [31:0] lfsr = 32'h0000_0011;
  logic [31:0] exp32;
  logic [15:0] exp16;
  logic [7:0]  expx;
  logic [31:0] w;
  logic [31:0] w2;
  logic        ord;

  cku_unit #(.ADDR_W(12)) u_cku_unit (
    .clock     (clock),
    .rstn      (rstn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hready    (hready),
    .hwdata    (hwdata),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp)
  );

  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reference arithmetic, written apart from the design's own
  function automatic logic [31:0] rand_word();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rand_word

  function automatic logic [31:0] ref_wide(input logic [31:0] c, input logic [31:0] d);
    for (int i = 31; i >= 0; i--)
      c = (c[31] ^ d[i]) ? ({c[30:0], 1'b0} ^ 32'h04C1_1DB7) : {c[30:0], 1'b0};
    return c;
  endfunction : ref_wide

  function automatic logic [15:0] ref_narrow(input logic [15:0] c, input logic [7:0] d,
                                             input logic lsb);
    logic b;
    for (int k = 0; k < 8; k++)
    begin
      b = lsb ? d[k] : d[7 - k];
      c = (c[15] ^ b) ? ({c[14:0], 1'b0} ^ 16'h8005) : {c[14:0], 1'b0};
    end
    return c;
  endfunction : ref_narrow

  // Byte and half data sit in the lanes picked by the low address bits
  function automatic logic [31:0] place(input logic [4:0] a, input logic [2:0] sz,
                                        input logic [31:0] d);
    if (sz == HSIZE_BYTE)
      return {24'h00_0000, d[7:0]} << (8 * a[1:0]);
    if (sz == HSIZE_HALF)
      return {16'h0000, d[15:0]} << (16 * a[1]);
    return d;
  endfunction : place

  ////////////////////////////////////////////////////////////////////////////
  // Bus tasks: requests change just after the falling edge
  task automatic bus_addr(input logic [4:0] a, input logic wr, input logic [2:0] sz);
    hsel = 1'b1;
    htrans = 2'h2;
    haddr = {7'h00, a};
    hwrite = wr;
    hsize = sz;
  endtask : bus_addr

  task automatic bus_idle();
    hsel = 1'b0;
    htrans = 2'h0;
  endtask : bus_idle

  task automatic bus_write(input logic [4:0] a, input logic [2:0] sz, input logic [31:0] d);
    @(negedge clock);
    bus_addr(a, 1'b1, sz);
    @(negedge clock);
    bus_idle();
    hwdata = place(a, sz, d);
  endtask : bus_write

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic expect_reg(input logic [4:0] a, input logic [31:0] exp, input string name);
    @(negedge clock);
    bus_addr(a, 1'b0, 3'h2);
    @(negedge clock);
    bus_idle();
    check(name, exp, hrdata);
    check("ready and response", 32'h0000_0002, {30'h0, hreadyout, hresp});
  endtask : expect_reg

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  // A hang counts as a mismatch; the whole sequence needs well under a thousand cycles
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      errors++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rstn = 1'b0;
    hsel = 1'b0;
    haddr = 12'h000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hready = 1'b1;
    hwdata = 32'h0000_0000;
    repeat (2) @(posedge clock);
    @(negedge clock);
    rstn = 1'b1;

    expect_reg(OFS_WIDE_DATA, 32'hFFFF_FFFF, "wide reset");
    for (int k = 1; k < 8; k++)
      expect_reg(5'(k * 4), 32'h0000_0000, "reset or unmapped");
    $display("test reset done");

    exp32 = 32'hFFFF_FFFF;
    repeat (16)
    begin
      w = rand_word();
      bus_write(OFS_WIDE_DATA, 3'h2, w);
      exp32 = ref_wide(exp32, w);
      expect_reg(OFS_WIDE_DATA, exp32, "wide result");
    end
    // Sub-word writes to the word data register must not feed the engine
    bus_write(OFS_WIDE_DATA, HSIZE_BYTE, rand_word());
    expect_reg(OFS_WIDE_DATA, exp32, "wide byte write");
    // Two writes back to back, then a read in the very next address phase
    w = rand_word();
    w2 = rand_word();
    @(negedge clock);
    bus_addr(OFS_WIDE_DATA, 1'b1, 3'h2);
    @(negedge clock);
    hwdata = w;
    @(negedge clock);
    hwdata = w2;
    bus_addr(OFS_WIDE_DATA, 1'b0, 3'h2);
    @(negedge clock);
    bus_idle();
    exp32 = ref_wide(ref_wide(exp32, w), w2);
    check("wide back to back", exp32, hrdata);
    $display("test wide engine done");

    w = rand_word();
    bus_write(OFS_SCRATCH, 3'h2, w);
    bus_write(OFS_WIDE_CTRL, 3'h2, 32'h0000_0000);
    expect_reg(OFS_WIDE_DATA, exp32, "reinit zero write");
    bus_write(OFS_WIDE_CTRL, 3'h2, 32'hFFFF_FFFF);
    expect_reg(OFS_WIDE_DATA, 32'hFFFF_FFFF, "reinit");
    expect_reg(OFS_WIDE_CTRL, 32'h0000_0000, "reinit self clear");
    expect_reg(OFS_SCRATCH, {24'h00_0000, w[7:0]}, "scratch");
    $display("test reinit and scratch done");

    for (int o = 0; o < 2; o++)
    begin
      ord = o[0];
      bus_write(OFS_NARROW_CTRL, 3'(o), {29'h0, 1'b1, ord, 1'b1});
      expect_reg(OFS_NARROW_RES, 32'h0000_0000, "wipe");
      expect_reg(OFS_NARROW_CTRL, {30'h0, ord, 1'b0}, "narrow control");
      expx = 8'(rand_word());
      bus_write(OFS_XOR_CHECK, HSIZE_BYTE, {24'h00_0000, expx});
      exp16 = 16'h0000;
      for (int k = 0; k < 12; k++)
      begin
        w = rand_word();
        bus_write(OFS_NARROW_IN, 3'(k % 3), w);
        exp16 = ref_narrow(exp16, w[7:0], ord);
        expx = expx ^ w[7:0];
        expect_reg(OFS_NARROW_RES, {16'h0000, exp16}, "narrow result");
        expect_reg(OFS_XOR_CHECK, {24'h00_0000, expx}, "xor check");
        expect_reg(OFS_NARROW_IN, {24'h00_0000, w[7:0]}, "narrow input");
      end
      bus_write(OFS_XOR_CHECK, 3'h2, 32'h0000_0000);
      expect_reg(OFS_XOR_CHECK, 32'h0000_0000, "xor clear");
    end
    $display("test narrow engine done");

    w = rand_word();
    bus_write(OFS_NARROW_RES, HSIZE_BYTE, w);
    bus_write(5'h15, HSIZE_BYTE, {24'h00_0000, w[15:8]});
    expect_reg(OFS_NARROW_RES, {16'h0000, w[15:0]}, "init by bytes");
    w2 = rand_word();
    bus_write(OFS_NARROW_IN, HSIZE_BYTE, w2);
    expect_reg(OFS_NARROW_RES, {16'h0000, ref_narrow(w[15:0], w2[7:0], ord)},
               "step from init");
    bus_write(OFS_NARROW_RES, HSIZE_HALF, w2);
    expect_reg(OFS_NARROW_RES, {16'h0000, w2[15:0]}, "init by half");
    bus_write(OFS_NARROW_RES, 3'h2, w);
    expect_reg(OFS_NARROW_RES, {16'h0000, w[15:0]}, "init by word");
    // A request held while hready is low is taken once, when hready rises
    @(negedge clock);
    hready = 1'b0;
    hwdata = 32'h0000_005A;
    bus_addr(OFS_NARROW_IN, 1'b1, HSIZE_BYTE);
    @(negedge clock);
    hready = 1'b1;
    @(negedge clock);
    bus_idle();
    expect_reg(OFS_XOR_CHECK, {24'h00_0000, w2[7:0] ^ 8'h5A}, "hready wait");
    $display("test narrow init done");

    tally_and_finish();
  end

endmodule : tb_cku_unit
